// file: hdl/efs_pkg.sv
/*
  Shared constants and types for the residual earth fault stage block.
  Assumes a single 10 MHz clock and a periodic processing cycle.
*/
package efs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 10000;                // 10 MHz clock
  localparam int CYCLE_MS     = 5;                    // Processing cycle
  localparam int CYCLE_CLKS   = CYCLE_MS * CLK_KHZ;   // Clocks per cycle
  localparam int BLOCK_LEAD_MS = 5;                   // Block lead before operate
  localparam int PRE_SHORT_MS = 20;                   // Short pre-trigger sample
  localparam int PRE_LONG_MS  = 200;                  // Long pre-trigger sample
  localparam int HIST_SHORT   = PRE_SHORT_MS / CYCLE_MS;
  localparam int HIST_DEPTH   = PRE_LONG_MS / CYCLE_MS;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_STAGES   = 4;
  localparam int REC_DEPTH    = 12;
  localparam int NUM_KINDS    = 7;
  localparam int EV_PER_STAGE = 2 * NUM_KINDS;
  localparam int EV_TOTAL     = NUM_STAGES * EV_PER_STAGE;
  localparam int MEAS_W       = 16;   // Measurement words
  localparam int HARM_W       = 16;   // Harmonic ratio, 0.01 % steps
  localparam int TIME_W       = 21;   // Milliseconds, up to 1800 s
  localparam int ACC_W        = 32;   // Inverse-time integral
  localparam int TS_W         = 48;   // Time stamp in milliseconds
  localparam int CNT_W        = 16;   // Cumulative counters

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [HARM_W-1:0] HARM_LIMIT_RST = 16'h0001;  // 0.01 %
  localparam logic              INRUSH_EN_RST  = 1'b0;

  // ----------------------------------------------------------------
  // Event kinds and stage states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_START, KIND_TRIP, KIND_BLOCK, KIND_WATT_START,
    KIND_VAR_START, KIND_WATT_TRIP, KIND_VAR_TRIP
  } efs_kind_t;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCKED} efs_state_t;

  // ----------------------------------------------------------------
  // Fault record layout, low bit first
  // ----------------------------------------------------------------
  localparam int RF_KIND    = 0;
  localparam int RF_TIME    = RF_KIND + 3;
  localparam int RF_PRE20   = RF_TIME + TS_W;
  localparam int RF_CUR     = RF_PRE20 + MEAS_W;
  localparam int RF_CAP     = RF_CUR + MEAS_W;
  localparam int RF_RES     = RF_CAP + MEAS_W;
  localparam int RF_U0PCT   = RF_RES + MEAS_W;
  localparam int RF_U0VOLT  = RF_U0PCT + MEAS_W;
  localparam int RF_ANGLE   = RF_U0VOLT + MEAS_W;
  localparam int RF_REMAIN  = RF_ANGLE + MEAS_W;
  localparam int RF_GROUP   = RF_REMAIN + TIME_W;
  localparam int RF_EARTH   = RF_GROUP + 3;
  localparam int RF_PRE200  = RF_EARTH + 2;
  localparam int REC_W      = RF_PRE200 + MEAS_W;

endpackage : efs_pkg

// file: hdl/efs_stage.sv
/*
  One protection stage: block evaluation, start/trip/blocked state and
  the definite or inverse delay timer with release handling.
  Assumes procTick is a one-clock pulse once per processing cycle.
*/
`timescale 1ns/10ps
module efs_stage (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  // Cycle strobe and stage inputs
  input  wire logic                           procTick,
  input  wire logic                           blockIn,
  input  wire logic                           pickUp,
  // Settings
  input  wire logic                           inrushEn,
  input  wire logic [efs_pkg::HARM_W-1:0]     harmRatio,
  input  wire logic [efs_pkg::HARM_W-1:0]     harmLimit,
  input  wire logic                           idmtMode,
  input  wire logic [efs_pkg::TIME_W-1:0]     dtDelayMs,
  input  wire logic [efs_pkg::ACC_W-1:0]      idmtK,
  input  wire logic [efs_pkg::TIME_W-1:0]     minTimeMs,
  input  wire logic [efs_pkg::TIME_W-1:0]     releaseMs,
  input  wire logic [efs_pkg::MEAS_W-1:0]     curRatio,
  // Stage state
  output logic                                startAct,
  output logic                                tripAct,
  output logic                                blockAct,
  output logic [efs_pkg::TIME_W-1:0]          remainMs
);

  // ----------------------------------------------------------------
  // Block and delay evaluation
  // ----------------------------------------------------------------
  efs_pkg::efs_state_t            stateQ, stateD;
  logic [efs_pkg::TIME_W-1:0]     elapsedQ, elapsedD, relQ, relD;
  logic [efs_pkg::ACC_W-1:0]      accQ, accD;

  localparam logic [efs_pkg::TIME_W-1:0] STEP_MS = efs_pkg::TIME_W'(efs_pkg::CYCLE_MS);
  localparam logic [efs_pkg::ACC_W-1:0]  STEP_ACC = efs_pkg::ACC_W'(efs_pkg::CYCLE_MS);

  // Inrush block only when enabled, at or above the limit
  wire                        harmBlk = inrushEn & (harmRatio >= harmLimit);  // [R3] [R4]
  wire                        blkNow  = blockIn | harmBlk;
  wire                        runNow  = pickUp & ~blkNow;                     // [R2]
  wire [efs_pkg::TIME_W-1:0]  elapNxt = elapsedQ + STEP_MS;
  wire [efs_pkg::ACC_W-1:0]   accNxt  = accQ + efs_pkg::ACC_W'(curRatio) * STEP_ACC;
  // Definite delay or integral with a minimum time
  wire tripDue = idmtMode ? ((accNxt >= idmtK) && (elapNxt >= minTimeMs))
                          : (elapNxt >= dtDelayMs);                           // [R8]
  wire [efs_pkg::TIME_W-1:0]  target  = idmtMode ? minTimeMs : dtDelayMs;

  // Next state, evaluated once per processing cycle
  always_comb begin
    stateD   = stateQ;
    elapsedD = elapsedQ;
    accD     = accQ;
    relD     = relQ;
    if (procTick) begin
      if (runNow) begin
        stateD   = tripDue ? efs_pkg::ST_TRIP : efs_pkg::ST_START;
        elapsedD = elapNxt;
        accD     = accNxt;
        relD     = '0;
      end else begin
        // Blocked pick-up does no timing; start drops into release
        stateD = pickUp ? efs_pkg::ST_BLOCKED : efs_pkg::ST_IDLE;        // [R5] [R6]
        if (relQ >= releaseMs) begin
          elapsedD = '0;
          accD     = '0;
        end else begin
          relD = relQ + STEP_MS;                                         // [R6]
        end
      end
    end
  end

  // State registers; block is sampled only on the cycle strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stateQ   <= efs_pkg::ST_IDLE;
      elapsedQ <= '0;
      accQ     <= '0;
      relQ     <= '0;
    end else begin
      stateQ   <= stateD;                                                // [R1]
      elapsedQ <= elapsedD;
      accQ     <= accD;
      relQ     <= relD;
    end
  end

  // Decoded state
  assign startAct = (stateQ == efs_pkg::ST_START) || (stateQ == efs_pkg::ST_TRIP);
  assign tripAct  = (stateQ == efs_pkg::ST_TRIP);
  assign blockAct = (stateQ == efs_pkg::ST_BLOCKED);
  assign remainMs = (target > elapsedQ) ? (target - elapsedQ) : '0;

endmodule : efs_stage

// file: hdl/efs_top.sv
/*
  Four residual earth fault stages with event generation, counters and
  twelve-entry fault records per stage.
  Assumes all inputs come from logic on mclk and a millisecond time stamp.
*/
`timescale 1ns/10ps
// Operation
// [R1] Block input sampled once each processing cycle from its dedicated port.
// [R2] Pick-up without block raises start and begins trip delay evaluation.
// [R3] Optional second-harmonic inrush block, off at reset, limit in 0.01 % steps. inrushEn and harmLimit are input ports with no reset value here.
// [R4] Inrush enabled and ratio at or above limit counts as blocked.
// [R5] Pick-up during block raises blocked, no further start or trip.
// [R6] Block after start drops start and runs release handling as pick-up reset.
// [R7] Block source asserts block at least 5 ms before operate delay ends.
// [R8] Trip delay selectable: definite time or inverse minimum-time characteristic.
// [R9] ON/OFF events for start, trip, block and wattmetric/varmetric start, trip.
// [R10] Events time stamped; per-event ON/OFF selection marks main-buffer storage.
// [R11] Cumulative counters increment on each start, trip and blocked.
// [R12] Four independent stages, each with separately identified events.
// [R13] Each stage keeps circular record of last twelve fault entries.
// [R14] Entry holds name, time, pre-trigger currents and fault quantities.
module efs_top #(
  parameter int CYCLE_CLKS = efs_pkg::CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   rst_n,
  // Stage inputs, one bit per stage
  input  wire logic [3:0]                             blockIn,
  input  wire logic [3:0]                             pickUp,
  input  wire logic [3:0]                             wattPickUp,
  input  wire logic [3:0]                             varPickUp,
  // Stage settings
  input  wire logic [3:0]                             inrushEn,
  input  wire logic [4*efs_pkg::HARM_W-1:0]           harmLimit,
  input  wire logic [3:0]                             idmtMode,
  input  wire logic [4*efs_pkg::TIME_W-1:0]           dtDelayMs,
  input  wire logic [4*efs_pkg::ACC_W-1:0]            idmtK,
  input  wire logic [4*efs_pkg::TIME_W-1:0]           minTimeMs,
  input  wire logic [4*efs_pkg::TIME_W-1:0]           releaseMs,
  input  wire logic [efs_pkg::NUM_KINDS-1:0]          evSelOn,
  input  wire logic [efs_pkg::NUM_KINDS-1:0]          evSelOff,
  // Measurements
  input  wire logic [efs_pkg::HARM_W-1:0]             harmRatio,
  input  wire logic [4*efs_pkg::MEAS_W-1:0]           curRatio,
  input  wire logic [efs_pkg::MEAS_W-1:0]             resCur,
  input  wire logic [efs_pkg::MEAS_W-1:0]             capCur,
  input  wire logic [efs_pkg::MEAS_W-1:0]             resistCur,
  input  wire logic [efs_pkg::MEAS_W-1:0]             u0Pct,
  input  wire logic [efs_pkg::MEAS_W-1:0]             u0Volt,
  input  wire logic [efs_pkg::MEAS_W-1:0]             faultAngle,
  input  wire logic [2:0]                             setGroup,
  input  wire logic [1:0]                             netEarth,
  input  wire logic [efs_pkg::TS_W-1:0]               timeStamp,
  // Counter access
  input  wire logic                                   cntClear,
  input  wire logic [1:0]                             cntStage,
  output logic [efs_pkg::CNT_W-1:0]                   startCnt,
  output logic [efs_pkg::CNT_W-1:0]                   tripCnt,
  output logic [efs_pkg::CNT_W-1:0]                   blockCnt,
  // Fault record access
  input  wire logic [1:0]                             recStage,
  input  wire logic [3:0]                             recIndex,
  output logic [efs_pkg::REC_W-1:0]                   recData,
  output logic                                        recValid,
  // Stage outputs
  output logic [3:0]                                  startOut,
  output logic [3:0]                                  tripOut,
  output logic [3:0]                                  blockedOut,
  // Event stream
  output logic                                        evValid,
  output logic [1:0]                                  evStage,
  output logic [2:0]                                  evKind,
  output logic                                        evOn,
  output logic                                        evStore,
  output logic [efs_pkg::TS_W-1:0]                    evTime
);

  localparam int NS = efs_pkg::NUM_STAGES;
  localparam int NK = efs_pkg::NUM_KINDS;
  localparam int NE = efs_pkg::EV_TOTAL;
  localparam int RD = efs_pkg::REC_DEPTH;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest pending event: {found, index}
  function automatic logic [7:0] firstSet(input logic [NE-1:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction : firstSet

  // Slot of an entry counted back from the write pointer
  function automatic logic [3:0] backSlot(input logic [3:0] ptr, input logic [3:0] back);
    logic [4:0] t;
    t = 5'(ptr) + 5'(RD) - 5'd1 - 5'(back);
    if (t >= 5'(RD)) begin
      t = t - 5'(RD);
    end
    return t[3:0];
  endfunction : backSlot

  // ----------------------------------------------------------------
  // Processing cycle strobe
  // ----------------------------------------------------------------
  logic [31:0] cycCntQ;
  logic        tickQ;

  // Free-running cycle divider
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cycCntQ <= '0;
      tickQ   <= 1'b0;
    end else begin
      tickQ   <= (cycCntQ == 32'(CYCLE_CLKS - 1));
      cycCntQ <= (cycCntQ == 32'(CYCLE_CLKS - 1)) ? '0 : cycCntQ + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Stages and status edges
  // ----------------------------------------------------------------
  logic [NS-1:0][NK-1:0]            statQ, prevQ, statD;
  logic [NS-1:0][efs_pkg::TIME_W-1:0] remain;
  logic [NE-1:0]                    newEv;

  for (genvar s = 0; s < NS; s++) begin : g_stage
    logic stSt, stTr, stBl;
    efs_stage u_stage (                                                   // [R12]
      .mclk      (mclk),
      .rst_n     (rst_n),
      .procTick  (tickQ),
      .blockIn   (blockIn[s]),
      .pickUp    (pickUp[s]),
      .inrushEn  (inrushEn[s]),
      .harmRatio (harmRatio),
      .harmLimit (harmLimit[s*efs_pkg::HARM_W +: efs_pkg::HARM_W]),
      .idmtMode  (idmtMode[s]),
      .dtDelayMs (dtDelayMs[s*efs_pkg::TIME_W +: efs_pkg::TIME_W]),
      .idmtK     (idmtK[s*efs_pkg::ACC_W +: efs_pkg::ACC_W]),
      .minTimeMs (minTimeMs[s*efs_pkg::TIME_W +: efs_pkg::TIME_W]),
      .releaseMs (releaseMs[s*efs_pkg::TIME_W +: efs_pkg::TIME_W]),
      .curRatio  (curRatio[s*efs_pkg::MEAS_W +: efs_pkg::MEAS_W]),
      .startAct  (stSt),
      .tripAct   (stTr),
      .blockAct  (stBl),
      .remainMs  (remain[s])
    );
    // Status vector in kind order; criteria qualify start and trip
    assign statD[s] = {varPickUp[s] & stTr, wattPickUp[s] & stTr,
                       varPickUp[s] & stSt, wattPickUp[s] & stSt,
                       stBl, stTr, stSt};                                 // [R9]
    for (genvar k = 0; k < NK; k++) begin : g_edge
      assign newEv[s*efs_pkg::EV_PER_STAGE + 2*k]     = statQ[s][k] & ~prevQ[s][k];
      assign newEv[s*efs_pkg::EV_PER_STAGE + 2*k + 1] = ~statQ[s][k] & prevQ[s][k];
    end
    assign startOut[s]   = statQ[s][efs_pkg::KIND_START];
    assign tripOut[s]    = statQ[s][efs_pkg::KIND_TRIP];
    assign blockedOut[s] = statQ[s][efs_pkg::KIND_BLOCK];
  end

  // ----------------------------------------------------------------
  // Event serialiser
  // ----------------------------------------------------------------
  logic [NE-1:0] pendQ;
  wire  [7:0]    pick    = firstSet(pendQ);
  wire           grant   = pick[7];
  wire  [6:0]    grIdx   = pick[6:0];
  wire  [1:0]    grStage = 2'(grIdx / 7'(efs_pkg::EV_PER_STAGE));
  wire  [3:0]    grRem   = 4'(grIdx % 7'(efs_pkg::EV_PER_STAGE));
  wire  [2:0]    grKind  = grRem[3:1];
  wire           grOn    = ~grRem[0];
  wire           grSel   = grOn ? evSelOn[grKind] : evSelOff[grKind];
  wire  [NE-1:0] grMask  = grant ? (NE'(1) << grIdx) : '0;
  // Fault entries come from start, trip and blocked ON edges
  wire           recWr   = grant & grOn & (grKind <= 3'(efs_pkg::KIND_BLOCK));

  // Status pipeline and pending events; a new edge wins over the grant
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      statQ <= '0;
      prevQ <= '0;
      pendQ <= '0;
    end else begin
      statQ <= statD;
      prevQ <= statQ;
      pendQ <= (pendQ & ~grMask) | newEv;                                 // [R9]
    end
  end

  // One event per clock, time stamped, with its storage selection
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      evValid <= 1'b0;
      evStage <= '0;
      evKind  <= '0;
      evOn    <= 1'b0;
      evStore <= 1'b0;
      evTime  <= '0;
    end else begin
      evValid <= grant;
      evStage <= grStage;                                                 // [R12]
      evKind  <= grKind;
      evOn    <= grOn;
      evStore <= grant & grSel;                                           // [R10]
      evTime  <= timeStamp;                                               // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Cumulative counters
  // ----------------------------------------------------------------
  logic [NS-1:0][2:0][efs_pkg::CNT_W-1:0] cntQ;

  // Count ON edges; an edge in the clear cycle counts as one
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cntQ <= '0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        for (int k = 0; k < 3; k++) begin
          if (newEv[s*efs_pkg::EV_PER_STAGE + 2*k]) begin
            cntQ[s][k] <= cntClear ? efs_pkg::CNT_W'(1) : cntQ[s][k] + 1'b1;  // [R11]
          end else if (cntClear) begin
            cntQ[s][k] <= '0;
          end
        end
      end
    end
  end

  // Counter readout
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      startCnt <= '0;
      tripCnt  <= '0;
      blockCnt <= '0;
    end else begin
      startCnt <= cntQ[cntStage][efs_pkg::KIND_START];
      tripCnt  <= cntQ[cntStage][efs_pkg::KIND_TRIP];
      blockCnt <= cntQ[cntStage][efs_pkg::KIND_BLOCK];
    end
  end

  // ----------------------------------------------------------------
  // Residual current history and fault records
  // ----------------------------------------------------------------
  logic [efs_pkg::MEAS_W-1:0] histQ [0:efs_pkg::HIST_DEPTH-1];
  logic [efs_pkg::REC_W-1:0]  recMem [0:NS*RD-1];
  logic [NS-1:0][3:0]         wrPtrQ, fillQ;

  // Assembled entry for the granted edge
  wire [efs_pkg::REC_W-1:0] recEntry = {
    histQ[efs_pkg::HIST_DEPTH-1], netEarth, setGroup, remain[grStage],
    faultAngle, u0Volt, u0Pct, resistCur, capCur, resCur,
    histQ[efs_pkg::HIST_SHORT-1], timeStamp, grKind};                     // [R14]
  wire [5:0] wrAddr = 6'(grStage * RD) + 6'(wrPtrQ[grStage]);
  wire [5:0] rdAddr = 6'(recStage * RD) + 6'(backSlot(wrPtrQ[recStage], recIndex));

  // History shifts once per processing cycle
  always_ff @(posedge mclk) begin
    if (tickQ) begin
      histQ[0] <= resCur;
      for (int i = 1; i < efs_pkg::HIST_DEPTH; i++) begin
        histQ[i] <= histQ[i-1];
      end
    end
  end

  // Circular record write, oldest entry overwritten
  always_ff @(posedge mclk) begin
    if (recWr) begin
      recMem[wrAddr] <= recEntry;                                         // [R13]
    end
  end

  // Write pointers and fill levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrPtrQ <= '0;
      fillQ  <= '0;
    end else if (recWr) begin
      wrPtrQ[grStage] <= (wrPtrQ[grStage] == 4'(RD - 1)) ? '0 : wrPtrQ[grStage] + 4'h1;
      fillQ[grStage]  <= (fillQ[grStage] == 4'(RD)) ? fillQ[grStage]
                                                    : fillQ[grStage] + 4'h1;  // [R13]
    end
  end

  // Record readout, index 0 is the newest entry
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      recData  <= '0;
      recValid <= 1'b0;
    end else begin
      recData  <= recMem[rdAddr];
      recValid <= (recIndex < fillQ[recStage]);
    end
  end

endmodule : efs_top

// file: verification/efs_blk_src.sv
/*
  Block source model: stands for the blocking matrix feeding blockIn.
  Assumes requests from the bench change only at the falling edge of mclk.
*/
`timescale 1ns/10ps
module efs_blk_src (
  // Clock and request
  input  wire logic       mclk,
  input  wire logic [3:0] blkReq,
  // Block lines to the stages
  output logic      [3:0] blockIn
);
  initial blockIn = 4'h0;
  // Passed on at each falling edge of mclk, long before any operate delay ends
  always @(negedge mclk) begin
    blockIn <= blkReq;
  end
endmodule : efs_blk_src

// file: verification/efs_top_sva.sv
/*
  Checker for stage status and event stream of efs_top.
  Assumes mclk rising edge and synchronous active-low rst_n.
*/
`timescale 1ns/10ps
module efs_top_sva #(
  parameter int CYCLE_CLKS = 60
) (
  input wire logic        mclk, rst_n, evValid, evOn, evStore, cntClear,
  input wire logic [3:0]  startOut, tripOut, blockedOut,
  input wire logic [1:0]  evStage,
  input wire logic [2:0]  evKind,
  input wire logic [6:0]  evSelOn, evSelOff,
  input wire logic [15:0] startCnt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Status exclusions
  start_vs_block_a: assert property ((startOut & blockedOut) == 4'h0)
    else $error("start and blocked together");
  trip_vs_block_a: assert property ((tripOut & blockedOut) == 4'h0)
    else $error("trip while blocked");
  trip_has_start_a: assert property ((tripOut & ~startOut) == 4'h0)
    else $error("trip without start");
  // Events follow the status they report
  start_event_a: assert property (evValid && evKind == 3'h0 |-> startOut[evStage] == evOn)
    else $error("start event disagrees with status");
  trip_event_a: assert property (evValid && evKind == 3'h1 |-> tripOut[evStage] == evOn)
    else $error("trip event disagrees with status");
  block_event_a: assert property (evValid && evKind == 3'h2 |-> blockedOut[evStage] == evOn)
    else $error("block event disagrees with status");
  start_rise_ev_a: assert property ($rose(startOut[0]) |->
    ##[1:60] (evValid && evStage == 2'h0 && evKind == 3'h0 && evOn))
    else $error("no start event after start rose");
  kind_range_a: assert property (evValid |-> evKind <= 3'h6)
    else $error("event kind out of range");
  // Storage selection and counter clear
  store_on_a: assert property (evValid && evOn |-> evStore == evSelOn[evKind])
    else $error("ON store bit wrong");
  store_off_a: assert property (evValid && !evOn |-> evStore == evSelOff[evKind])
    else $error("OFF store bit wrong");
  clear_cnt_a: assert property (cntClear [*3] |-> startCnt <= 16'h0001)
    else $error("counter not cleared");
  // Main scenarios
  start_c: cover property ($rose(startOut[0]));
  block_c: cover property ($rose(blockedOut[1]));
  trip_c: cover property ($rose(tripOut[3]));
endmodule : efs_top_sva

bind efs_top efs_top_sva #(.CYCLE_CLKS(CYCLE_CLKS)) chk (.mclk(mclk), .rst_n(rst_n),
  .evValid(evValid), .evOn(evOn), .evStore(evStore), .cntClear(cntClear),
  .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut), .evStage(evStage),
  .evKind(evKind), .evSelOn(evSelOn), .evSelOff(evSelOff), .startCnt(startCnt));

// file: verification/testbench.sv
/*
  Self-checking bench for efs_top with a short processing cycle.
  Assumes the block source model and the bound checker.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0, cntClear = 1'b1;
  logic [3:0] pickUp = 4'h0, blkReq = 4'h0, blockIn, wattPU = 4'h0, inrushEn = 4'h0;
  logic [15:0] harmRatio = 16'h0000, startCnt, tripCnt, blockCnt;
  logic [1:0] cntStage = 2'h0, recStage = 2'h0, evStage;
  logic [3:0] recIndex = 4'h0, startOut, tripOut, blockedOut;
  logic [47:0] timeStamp = 48'h0, evTime;
  logic [efs_pkg::REC_W-1:0] recData;
  logic recValid, evValid, evOn, evStore;
  logic [2:0] evKind;
  logic [3:0] varPU = 4'h0, idmtMode = 4'h0;
  logic [6:0] evSelOn = 7'h7F, evSelOff = 7'h55;
  logic [15:0] resCur = 16'h0123;
  logic [2:0] setGroup = 3'h5;
  logic [1:0] netEarth = 2'h1;
  logic [63:0] harmLimit = {16'h0001, 16'h0100, 16'h0001, 16'h0001}, curRatio = {4{16'h0200}};
  logic [83:0] dtDelayMs = {4{21'h00014}}, minTimeMs = 84'h0, releaseMs = 84'h0;
  logic [127:0] idmtK = {4{32'h0000FFFF}};
  logic [55:0] evSeen = '0;
  int mismatches = 0, samples_checked = 0, cyc = 0;

  efs_blk_src src (.mclk(mclk), .blkReq(blkReq), .blockIn(blockIn));
  efs_top #(.CYCLE_CLKS(60)) dut (.mclk(mclk), .rst_n(rst_n), .blockIn(blockIn),
    .pickUp(pickUp), .wattPickUp(wattPU), .varPickUp(varPU), .inrushEn(inrushEn),
    .harmLimit(harmLimit), .idmtMode(idmtMode), .dtDelayMs(dtDelayMs), .idmtK(idmtK),
    .minTimeMs(minTimeMs), .releaseMs(releaseMs), .evSelOn(evSelOn), .evSelOff(evSelOff),
    .harmRatio(harmRatio), .curRatio(curRatio), .resCur(resCur), .capCur(16'h0045),
    .resistCur(16'h0067), .u0Pct(16'h0500), .u0Volt(16'h1000), .faultAngle(16'h00B4),
    .setGroup(setGroup), .netEarth(netEarth), .timeStamp(timeStamp), .cntClear(cntClear),
    .cntStage(cntStage),
    .startCnt(startCnt), .tripCnt(tripCnt), .blockCnt(blockCnt), .recStage(recStage),
    .recIndex(recIndex), .recData(recData), .recValid(recValid), .startOut(startOut),
    .tripOut(tripOut), .blockedOut(blockedOut), .evValid(evValid), .evStage(evStage),
    .evKind(evKind), .evOn(evOn), .evStore(evStore), .evTime(evTime));

  always #50 mclk = ~mclk;
  // Millisecond stamp and event capture, index stage*14+kind*2+off
  always @(negedge mclk) timeStamp <= timeStamp + 48'h1;
  always @(negedge mclk) begin
    cyc++;
    if (evValid === 1'b1) begin
      evSeen[int'(evStage) * 14 + int'(evKind) * 2 + int'(!evOn)] <= 1'b1;
      `CHK(evTime, timeStamp)
    end
    if (cyc == 12000) begin
      mismatches++;
      results();
    end
  end

  task automatic wait_ev(input int idx);
    int n;
    n = 0;
    while (evSeen[idx] !== 1'b1 && n < 1500) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_ev

  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask : settle

  // Stage 0 starts with no block
  task automatic t_start();
    evSeen = '0;
    pickUp[0] = 1'b1;
    wait_ev(0);
    `CHK(evSeen[0], 1'b1)
    `CHK(startOut[0], 1'b1)
    `CHK(blockedOut[0], 1'b0)
    settle(3);
    `CHK(startCnt, 16'h0001)
  endtask : t_start

  // Stage 1 picks up under block
  task automatic t_block();
    evSeen = '0;
    blkReq[1] = 1'b1;
    settle(2);
    pickUp[1] = 1'b1;
    wait_ev(18);
    `CHK(evSeen[18], 1'b1)
    `CHK(startOut[1], 1'b0)
    cntStage = 2'h1;
    settle(3);
    `CHK(blockCnt, 16'h0001)
  endtask : t_block

  // Block arrives on started stage 0
  task automatic t_release();
    evSeen = '0;
    blkReq[0] = 1'b1;
    wait_ev(1);
    `CHK(evSeen[1], 1'b1)
    `CHK(startOut[0], 1'b0)
    wait_ev(4);
    `CHK(evSeen[4], 1'b1)
    pickUp[0] = 1'b0;
  endtask : t_release

  // Stage 2 inrush at the limit, then just below
  task automatic t_inrush();
    evSeen = '0;
    inrushEn[2] = 1'b1;
    idmtMode[2] = 1'b1;
    curRatio[47:32] = 16'h3000;
    varPU[2] = 1'b1;
    harmRatio = 16'h0100;
    pickUp[2] = 1'b1;
    wait_ev(32);
    `CHK(evSeen[32], 1'b1)
    `CHK(startOut[2], 1'b0)
    harmRatio = 16'h00FF;
    wait_ev(28);
    `CHK(evSeen[28], 1'b1)
    settle(70);
    `CHK(tripOut[2], 1'b1)
    `CHK(evSeen[36], 1'b1)
  endtask : t_inrush

  // Stage 3 definite delay trip, inrush off, records
  task automatic t_trip();
    evSeen = '0;
    wattPU[3] = 1'b1;
    pickUp[3] = 1'b1;
    wait_ev(42);
    `CHK(evSeen[42], 1'b1)
    settle(120);
    `CHK(tripOut[3], 1'b0)
    wait_ev(44);
    `CHK(evSeen[44], 1'b1)
    wait_ev(52);
    `CHK(evSeen[48], 1'b1)
    `CHK(evSeen[52], 1'b1)
    `CHK(evSeen[50], 1'b0)
    `CHK(evSeen[2], 1'b0)
    cntStage = 2'h3;
    recStage = 2'h3;
    settle(3);
    `CHK(tripCnt, 16'h0001)
    `CHK(recValid, 1'b1)
    `CHK(recData[2:0], 3'h1)
    `CHK(recData[efs_pkg::RF_GROUP +: 3], 3'h5)
    recIndex = 4'h1;
    settle(3);
    `CHK(recData[2:0], 3'h0)
    recIndex = 4'h2;
    settle(3);
    `CHK(recValid, 1'b0)
  endtask : t_trip

  task automatic results();
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    settle(12);
    rst_n = 1'b1;
    settle(3);
    cntClear = 1'b0;
    t_start();
    t_block();
    t_release();
    t_inrush();
    t_trip();
    results();
  end
endmodule : testbench
